// File: hw/rampg_defs.svh
// constants of the ramp generator: field positions, reset values, counts
// assumes register contents arrive as plain ports, system clock I_MCLK
//
// Behaviour
// - 32-bit accumulator stepped by DDS-rate interval timer
// - add rising step, subtract falling step
// - phase/amplitude take top 16/14 bits
// - enable rising at update reloads the timer
// - direction input change reloads the timer
// - reload-on-update bit lets strobe reload timer
// - output stays within limits while enabled
// - cleared accumulator means output at lower limit
// - normal ramp only with no-dwell bits clear
// - enable/clear/autoclear act only after update strobe
// - enable with direction low starts at lower
// - hold at upper until clear, down, raise
// - hold at lower until up or lowered
// - freeze input stalls accumulator, then resumes
// - clear bit holds lower until strobed off
// - autoclear holds reset one DDS cycle
// - direction selects falling or rising parameters
// - destination code routes output MSB-aligned
// - disabled ramp ignores inputs, timer stopped
// - limit status high at either limit while enabled
`ifndef RAMPG_DEFS_SVH
`define RAMPG_DEFS_SVH
`define RAMPG_RISE_IV_LSB 16
`define RAMPG_FALL_IV_LSB 0
`define RAMPG_RISE_STEP_LSB 0
`define RAMPG_FALL_STEP_LSB 32
`define RAMPG_LOWER_LSB 0
`define RAMPG_UPPER_LSB 32
`define RAMPG_PH_LSB 16
`define RAMPG_AMP_LSB 18
`define RAMPG_PRE_LAST 2'h3
`define RAMPG_PRE_RST 2'h0
`define RAMPG_ACC_RST 32'h0
`define RAMPG_IV_MIN 16'h0001
`endif

// File: hw/rampg_pkg.sv
// types shared by the ramp generator modules
// assumes rampg_defs.svh for all numeric constants
`default_nettype none
package rampg_pkg;
  typedef enum logic [1:0] {
    RAMPG_FREQ = 2'h0,
    RAMPG_PHASE = 2'h1,
    RAMPG_AMPL = 2'h2,
    RAMPG_AMPL_X = 2'h3
  } rampg_dest_e;
  // gray along idle, run, clear, autoclear
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_RUN = 2'h1,
    M_CLR = 2'h3,
    M_ACLR = 2'h2
  } rampg_mode_e;
  typedef struct packed {
    logic [2:0] dir_sy;
    logic [2:0] frz_sy;
    logic dir;
    logic frz;
    logic en;
    logic clr;
    rampg_mode_e mode;
    logic [31:0] acc;
    logic [31:0] freq;
    logic [15:0] ph;
    logic [13:0] amp;
    logic lim;
  } rampg_top_s;
  typedef struct packed {
    logic [1:0] pre;
    logic [15:0] cnt;
    logic exp;
  } rampg_tmr_s;
endpackage : rampg_pkg
`default_nettype wire

// File: hw/rampg_tmr_if.sv
// carrier between ramp control and its interval timer
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface rampg_tmr_if #(parameter int IW = 16);
  logic reload;
  logic run;
  logic [IW-1:0] interval;
  logic tick;
  logic expire;
  modport ctl(output reload, output run, output interval, input tick, input expire);
  modport tmr(input reload, input run, input interval, output tick, output expire);
endinterface : rampg_tmr_if
`default_nettype wire

// File: hw/rampg_timer.sv
// step interval timer: DDS-rate prescaler and down counter
// assumes I_MCLK is the system clock, DDS clock a quarter of it
`timescale 1ns/100ps
`default_nettype none
`include "rampg_defs.svh"
module rampg_timer #(parameter int IW = 16) (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  rampg_tmr_if.tmr tif
);
  import rampg_pkg::*;
  rampg_tmr_s q;
  rampg_tmr_s n;
  logic [IW-1:0] iv;
  // zero interval taken as one, avoids a dead timer
  assign iv = (tif.interval == '0) ? IW'(`RAMPG_IV_MIN) : tif.interval;
  assign tif.tick = (q.pre == `RAMPG_PRE_LAST);
  assign tif.expire = q.exp;
  always_comb begin
    n = q;
    n.exp = 1'b0;
    n.pre = q.pre + 2'h1;
    if (tif.reload) begin
      n.pre = `RAMPG_PRE_RST;
      n.cnt = iv;
    end else if (tif.run && tif.tick) begin
      if (q.cnt <= 16'h0001) begin
        n.cnt = iv;
        n.exp = 1'b1;
      end else begin
        n.cnt = q.cnt - 16'h0001;
      end
    end
  end
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : rampg_timer
`default_nettype wire

// File: hw/rampg_top.sv
// digital ramp generator: accumulator, limits, control strobe, routing
// assumes register contents as ports, pins asynchronous to I_MCLK
`timescale 1ns/100ps
`default_nettype none
`include "rampg_defs.svh"
module rampg_top (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic [31:0] I_RAMP_INTERVAL,
  input wire logic [63:0] I_RAMP_STEP_SIZES,
  input wire logic [63:0] I_RAMP_LIMITS,
  input wire rampg_pkg::rampg_dest_e I_DEST,
  input wire logic [1:0] I_NO_DWELL,
  input wire logic I_ENABLE,
  input wire logic I_CLEAR,
  input wire logic I_AUTOCLEAR,
  input wire logic I_RELOAD_ON_UPDATE,
  input wire logic I_IO_UPDATE,
  input wire logic I_SLOPE_DIRECTION_IN,
  input wire logic I_RAMP_FREEZE_IN,
  output logic [31:0] O_RAMP_OUT,
  output logic [31:0] O_FREQ_WORD,
  output logic [15:0] O_PHASE_WORD,
  output logic [13:0] O_AMPL_WORD,
  output logic O_LIMIT_STATUS_OUT
);
  import rampg_pkg::*;

  rampg_top_s q;
  rampg_top_s n;
  rampg_tmr_if #(.IW(16)) tif ();

  logic [31:0] up;
  logic [31:0] lo;
  logic [31:0] rise;
  logic [31:0] fall;
  logic [15:0] iv_rise;
  logic [15:0] iv_fall;
  logic normal;
  logic reload;
  logic en_rise;
  logic [32:0] sum;
  logic [32:0] diff;

  assign up = I_RAMP_LIMITS[`RAMPG_UPPER_LSB +: 32];
  assign lo = I_RAMP_LIMITS[`RAMPG_LOWER_LSB +: 32];
  assign rise = I_RAMP_STEP_SIZES[`RAMPG_RISE_STEP_LSB +: 32];
  assign fall = I_RAMP_STEP_SIZES[`RAMPG_FALL_STEP_LSB +: 32];
  assign iv_rise = I_RAMP_INTERVAL[`RAMPG_RISE_IV_LSB +: 16];
  assign iv_fall = I_RAMP_INTERVAL[`RAMPG_FALL_IV_LSB +: 16];
  assign normal = (I_NO_DWELL == 2'h0);
  assign en_rise = I_IO_UPDATE && I_ENABLE && !q.en;

  // timer control; interval follows the settled direction
  assign tif.interval = n.dir ? iv_rise : iv_fall;
  assign tif.reload = reload;
  // stopped while idle, frozen, clearing or outside normal mode
  assign tif.run = (q.mode == M_RUN) && !q.frz && normal;

  rampg_timer #(.IW(16)) u_timer (
    .I_MCLK(I_MCLK),
    .I_RESETN(I_RESETN),
    .tif(tif)
  );

  always_comb begin
    sum = {1'b0, q.acc} + {1'b0, rise};
    diff = {1'b0, q.acc} - {1'b0, fall};
  end

  always_comb begin
    n = q;
    // three-stage pin synchronisers; change taken once stages 2 and 3 agree
    n.dir_sy = {q.dir_sy[1:0], I_SLOPE_DIRECTION_IN};
    n.frz_sy = {q.frz_sy[1:0], I_RAMP_FREEZE_IN};
    if (q.dir_sy[1] == q.dir_sy[2]) begin
      n.dir = q.dir_sy[2];
    end
    if (q.frz_sy[1] == q.frz_sy[2]) begin
      n.frz = q.frz_sy[2];
    end
    // control bits only move at the strobe
    if (I_IO_UPDATE) begin
      n.en = I_ENABLE;
      n.clr = I_CLEAR;
    end
    reload = (n.dir != q.dir)
      || en_rise
      || (I_IO_UPDATE && I_RELOAD_ON_UPDATE)
      || (I_IO_UPDATE && I_AUTOCLEAR && I_ENABLE);
    // mode selection
    if (!n.en) begin
      n.mode = M_IDLE;
    end else if (n.clr) begin
      n.mode = M_CLR;
    end else if (I_IO_UPDATE && I_AUTOCLEAR) begin
      n.mode = M_ACLR;
    end else if (q.mode == M_ACLR && !tif.tick) begin
      n.mode = M_ACLR;
    end else begin
      n.mode = M_RUN;
    end
    // accumulator
    case (n.mode)
      M_IDLE: begin
        n.acc = q.acc;
      end
      M_CLR, M_ACLR: begin
        n.acc = lo;
      end
      M_RUN: begin
        if (q.mode == M_IDLE && !n.dir) begin
          n.acc = lo;
        end else if (tif.expire && normal && !q.frz) begin
          if (q.dir) begin
            n.acc = (sum > {1'b0, up}) ? up : sum[31:0];
          end else if (diff[32] || diff[31:0] < lo) begin
            n.acc = lo;
          end else begin
            n.acc = diff[31:0];
          end
        end
        // live limits: a raised or lowered limit lets the slope resume
        if (n.acc > up) begin
          n.acc = up;
        end
        if (n.acc < lo) begin
          n.acc = lo;
        end
      end
      default: begin
        n.acc = q.acc;
      end
    endcase
    // MSB-aligned routing, truncation of unused low bits
    n.freq = (I_DEST == RAMPG_FREQ) ? n.acc : 32'h0;
    n.ph = (I_DEST == RAMPG_PHASE) ? n.acc[`RAMPG_PH_LSB +: 16] : 16'h0;
    n.amp = I_DEST[1] ? n.acc[`RAMPG_AMP_LSB +: 14] : 14'h0;
    n.lim = n.en && ((n.acc == up) || (n.acc == lo));
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign O_RAMP_OUT = q.acc;
  assign O_FREQ_WORD = q.freq;
  assign O_PHASE_WORD = q.ph;
  assign O_AMPL_WORD = q.amp;
  assign O_LIMIT_STATUS_OUT = q.lim;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESETN);

  a_clear_at_lower:
    assert property (
      (q.mode == M_CLR) |-> (q.acc == $past(lo))
    ) else $error("clear does not hold lower limit");

  a_upper_bound:
    assert property (
      (q.mode == M_RUN && $past(lo) < $past(up))
        |-> (q.acc <= $past(up))
    ) else $error("output above upper limit");

  a_lower_bound:
    assert property (
      (q.mode == M_RUN && $past(lo) < $past(up))
        |-> (q.acc >= $past(lo))
    ) else $error("output below lower limit");

  a_freeze_stalls:
    assert property (
      (q.frz && q.mode == M_RUN) |=> !tif.expire
    ) else $error("step taken while frozen");

  a_disabled_still:
    assert property (
      (!q.en ##1 !q.en) |-> $stable(q.acc)
    ) else $error("accumulator moved while disabled");

  a_reload_spacing:
    assert property (
      tif.reload |=> (!tif.expire)[*4]
    ) else $error("expiry sooner than four clocks after reload");

  a_rise_steps_up:
    assert property (
      (tif.expire && q.mode == M_RUN && q.dir && !q.frz && normal)
        |=> ($stable(I_RAMP_LIMITS) -> q.acc >= $past(q.acc))
    ) else $error("rising slope stepped down");

  a_fall_steps_down:
    assert property (
      (tif.expire && q.mode == M_RUN && !q.dir && !q.frz && normal)
        |=> ($stable(I_RAMP_LIMITS) -> q.acc <= $past(q.acc))
    ) else $error("falling slope stepped up");

  a_autoclear_len:
    assert property (
      ($rose(q.mode == M_ACLR) && !I_IO_UPDATE)
        |-> (q.mode == M_ACLR)[*4] ##1 (q.mode != M_ACLR)
    ) else $error("autoclear not one DDS cycle");

  a_limit_flag:
    assert property (
      q.lim == (q.en && (q.acc == $past(up) || q.acc == $past(lo)))
    ) else $error("limit status wrong");

  a_phase_route:
    assert property (
      q.ph == (($past(I_DEST) == RAMPG_PHASE) ? q.acc[31:16] : 16'h0)
    ) else $error("phase word not upper 16 bits");

  a_enable_low_dir:
    assert property (
      (q.mode == M_RUN && $past(q.mode) == M_IDLE && !q.dir)
        |-> (q.acc == $past(lo))
    ) else $error("enable with direction low not at lower");

  a_dir_reload:
    assert property (
      $changed(q.dir) |-> $past(tif.reload)
    ) else $error("direction change did not reload timer");

  a_tick_rate:
    assert property (
      tif.tick |=> (!tif.tick)[*3]
    ) else $error("dds tick faster than a quarter clock");

  a_freq_route:
    assert property (
      q.freq == (($past(I_DEST) == RAMPG_FREQ) ? q.acc : 32'h0)
    ) else $error("frequency word not full output");

  a_ampl_route:
    assert property (
      q.amp == ($past(I_DEST[1]) ? q.acc[31:18] : 14'h0)
    ) else $error("amplitude word not upper 14 bits");

  a_no_dwell_stop:
    assert property (
      !normal |=> !tif.expire
    ) else $error("step timed outside normal mode");

  a_strobe_only:
    assert property (
      !I_IO_UPDATE |=> ($stable(q.en) && $stable(q.clr))
    ) else $error("control bits moved without strobe");

  a_update_reload:
    assert property (
      (I_IO_UPDATE && I_RELOAD_ON_UPDATE) |=> (!tif.expire)[*4]
    ) else $error("strobe did not reload timer");

  a_enable_reload:
    assert property (
      (I_IO_UPDATE && I_ENABLE && !q.en) |=> (!tif.expire)[*4]
    ) else $error("enable did not reload timer");

  // step sizes checked only clear of the limits; clamping has its own checks
  a_rise_step:
    assert property (
      (tif.expire && q.mode == M_RUN && q.dir && !q.frz && normal && !I_IO_UPDATE
        && ({1'b0, q.acc} + {1'b0, rise}) <= {1'b0, up} && q.acc >= lo)
        |=> (q.acc == $past(q.acc) + $past(rise))
    ) else $error("rising step size wrong");

  a_fall_step:
    assert property (
      (tif.expire && q.mode == M_RUN && !q.dir && !q.frz && normal && !I_IO_UPDATE
        && q.acc >= fall && (q.acc - fall) >= lo && q.acc <= up)
        |=> (q.acc == $past(q.acc) - $past(fall))
    ) else $error("falling step size wrong");

  a_freeze_holds:
    assert property (
      (q.frz && q.mode == M_RUN && !I_IO_UPDATE && $stable(I_RAMP_LIMITS))
        |=> $stable(q.acc)
    ) else $error("output moved while frozen");

  a_upper_holds:
    assert property (
      (q.mode == M_RUN && q.dir && q.acc == up && lo < up && !I_IO_UPDATE)
        |=> $stable(q.acc)
    ) else $error("output left upper limit");

  a_lower_holds:
    assert property (
      (q.mode == M_RUN && !q.dir && q.acc == lo && lo < up && !I_IO_UPDATE)
        |=> $stable(q.acc)
    ) else $error("output left lower limit");

  a_aclr_lower:
    assert property (
      (q.mode == M_ACLR) |-> (q.acc == $past(lo))
    ) else $error("autoclear does not hold lower limit");

  a_idle_stopped:
    assert property (
      (q.mode == M_IDLE) |=> !tif.expire
    ) else $error("timer expired while disabled");

endmodule : rampg_top
`default_nettype wire

// File: tb/rampg_host.sv
// host model: control bits, update strobe, direction and freeze pins
// assumes i_clk is the ramp generator's I_MCLK; drives at falling edges
`timescale 1ns/100ps
`default_nettype none
module rampg_host (
  input wire logic i_clk,
  output logic o_enable,
  output logic o_clear,
  output logic o_autoclear,
  output logic o_io_update,
  output logic o_dir,
  output logic o_freeze
);
  initial begin
    {o_enable, o_clear, o_autoclear, o_io_update, o_dir, o_freeze} = 6'h00;
  end
  // bits may change at any time; only a strobe makes them count
  task automatic write_ctl(input logic en, input logic clr, input logic aclr);
    @(negedge i_clk);
    {o_enable, o_clear, o_autoclear} = {en, clr, aclr};
  endtask : write_ctl
  // one-cycle pulse; returns at the falling edge that drops it, no idle cycle after
  task automatic update();
    @(negedge i_clk);
    o_io_update = 1'b1;
    @(negedge i_clk);
    o_io_update = 1'b0;
  endtask : update
  task automatic pins(input logic dir, input logic frz);
    @(negedge i_clk);
    {o_dir, o_freeze} = {dir, frz};
  endtask : pins
endmodule : rampg_host
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the ramp generator top
// assumes rampg_host drives control pins; bench drives register words
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rampg_pkg::*;
  localparam logic [15:0] P = 16'h0002;
  logic i_mclk, i_resetn, reload;
  logic [31:0] intv, ramp, freq, v;
  logic [63:0] steps, lims;
  rampg_dest_e dest;
  logic [1:0] nodwell;
  wire logic en, clr, aclr, upd, dir, frz;
  logic [15:0] ph;
  logic [13:0] amp;
  logic lim;
  int error_cnt, checks, cycles, n;
  rampg_host host_u (.i_clk(i_mclk), .o_enable(en), .o_clear(clr), .o_autoclear(aclr),
    .o_io_update(upd), .o_dir(dir), .o_freeze(frz));
  // no-dwell modes not built; only the stall they cause is driven
  rampg_top dut_u (.I_MCLK(i_mclk), .I_RESETN(i_resetn), .I_RAMP_INTERVAL(intv),
    .I_RAMP_STEP_SIZES(steps), .I_RAMP_LIMITS(lims), .I_DEST(dest), .I_NO_DWELL(nodwell),
    .I_ENABLE(en), .I_CLEAR(clr), .I_AUTOCLEAR(aclr), .I_RELOAD_ON_UPDATE(reload),
    .I_IO_UPDATE(upd), .I_SLOPE_DIRECTION_IN(dir), .I_RAMP_FREEZE_IN(frz),
    .O_RAMP_OUT(ramp), .O_FREQ_WORD(freq), .O_PHASE_WORD(ph), .O_AMPL_WORD(amp),
    .O_LIMIT_STATUS_OUT(lim));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // whole run is under a thousand cycles
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for the next change of the ramp output
  task automatic wait_step(output int k);
    logic [31:0] old;
    old = ramp;
    k = 0;
    do begin
      @(negedge i_mclk);
      k++;
    end while (ramp === old && k < 200);
  endtask : wait_step
  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    i_resetn = 1'b0;
    reload = 1'b0;
    nodwell = 2'h0;
    dest = RAMPG_FREQ;
    intv = {P, 16'h0001};
    steps = {32'h0000_0080, 32'h0000_0100};
    lims = {32'h0000_0400, 32'h0000_0100};
    repeat (2) @(negedge i_mclk);
    check("reset", ramp, 32'h0);
    i_resetn = 1'b1;
    host_u.write_ctl(1'b1, 1'b0, 1'b0);
    repeat (4) @(negedge i_mclk);
    check("unstrobed", ramp, 32'h0);
    host_u.update();
    check("start", ramp, 32'h0000_0100);
    check("freq", freq, 32'h0000_0100);
    check("lim low", 32'(lim), 32'h1);
    host_u.pins(1'b1, 1'b0);
    wait_step(n);
    check("dir delay", 32'(n >= 12 && n <= 15), 32'h1);
    check("rise", ramp, 32'h0000_0200);
    wait_step(n);
    check("rise period", n, 32'(4 * P));
    check("lim mid", 32'(lim), 32'h0);
    repeat (40) @(negedge i_mclk);
    check("upper hold", ramp, 32'h0000_0400);
    check("lim up", 32'(lim), 32'h1);
    lims[63:32] = 32'h0000_0800;
    wait_step(n);
    check("raised", ramp, 32'h0000_0500);
    host_u.pins(1'b1, 1'b1);
    repeat (40) @(negedge i_mclk);
    check("frozen", ramp, 32'h0000_0500);
    host_u.pins(1'b1, 1'b0);
    wait_step(n);
    check("resume", ramp, 32'h0000_0600);
    host_u.pins(1'b0, 1'b0);
    wait_step(n);
    check("fall", ramp, 32'h0000_0580);
    wait_step(n);
    check("fall period", n, 32'h4);
    repeat (60) @(negedge i_mclk);
    check("lower hold", ramp, 32'h0000_0100);
    lims[31:0] = 32'h0000_0000;
    wait_step(n);
    check("lowered", ramp, 32'h0000_0080);
    lims[31:0] = 32'h0000_0100;
    repeat (2) @(negedge i_mclk);
    check("clamp", ramp, 32'h0000_0100);
    host_u.pins(1'b1, 1'b0);
    host_u.write_ctl(1'b1, 1'b1, 1'b0);
    host_u.update();
    repeat (30) @(negedge i_mclk);
    check("cleared", ramp, 32'h0000_0100);
    host_u.write_ctl(1'b1, 1'b0, 1'b0);
    host_u.update();
    wait_step(n);
    check("unclear", ramp, 32'h0000_0200);
    wait_step(n);
    host_u.write_ctl(1'b1, 1'b0, 1'b1);
    host_u.update();
    check("autoclr", ramp, 32'h0000_0100);
    wait_step(n);
    check("autoclr run", ramp, 32'h0000_0200);
    host_u.write_ctl(1'b1, 1'b0, 1'b0);
    reload = 1'b1;
    wait_step(n);
    v = ramp;
    // a strobe every 2 clocks keeps an 8-clock timer from ever expiring
    repeat (8) host_u.update();
    check("reload hold", ramp, v);
    reload = 1'b0;
    repeat (8) host_u.update();
    check("no reload", 32'(ramp !== v), 32'h1);
    nodwell = 2'h3;
    v = ramp;
    repeat (20) @(negedge i_mclk);
    check("no dwell", ramp, v);
    nodwell = 2'h0;
    lims = {32'hFFFF_FF00, 32'hABCD_E100};
    host_u.write_ctl(1'b1, 1'b1, 1'b0);
    host_u.update();
    for (int d = 0; d < 4; d++) begin
      dest = rampg_dest_e'(d);
      repeat (2) @(negedge i_mclk);
      check("freq", freq, d == 0 ? 32'hABCD_E100 : 32'h0);
      check("phase", 32'(ph), d == 1 ? 32'h0000_ABCD : 32'h0);
      check("ampl", 32'(amp), d > 1 ? 32'h0000_2AF3 : 32'h0);
    end
    host_u.write_ctl(1'b0, 1'b0, 1'b0);
    host_u.update();
    v = ramp;
    repeat (30) @(negedge i_mclk);
    check("disabled", ramp, v);
    host_u.write_ctl(1'b1, 1'b0, 1'b0);
    host_u.update();
    wait_step(n);
    // reload edge plus 4P clocks plus the registered expiry
    check("enable reload", n, 32'(4 * P + 1));
    check("enable rise", ramp, 32'hABCD_E200);
    steps[31:0] = 32'h8000_0000;
    wait_step(n);
    check("wide step", ramp, 32'hFFFF_FF00);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
